// ==== scod_diag.sv ====
/*
 * Stack over/under-voltage and cell open-wire fault logic.
 * Assumes the conversion routine runs on clk and gives one-cycle step
 * strobes with results valid beside them; comparator inputs are async.
 */
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "scod_map.svh"

module scod_diag
    import scod_pkg::*;
#(
    parameter int NC = 14,
    parameter int FILT_CYC = `SCOD_FILT_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic cell_step_done,
    input wire logic [NC*16-1:0] cell_res,
    input wire logic supply_step_done,
    input wire logic [15:0] supply_res,
    input wire logic term_step_start,
    input wire logic term_step_done,
    input wire logic [NC*16-1:0] term_drop,
    input wire logic [NC*8-1:0] pair_odd_res_lo,
    input wire logic [NC*8-1:0] pair_even_res_lo,
    input wire logic c0_open_cmp,
    input wire logic warn_ov_cmp,
    input wire logic warn_uv_cmp,
    output logic fault_line,
    output logic cfg_override,
    output logic balance_stop_all,
    output logic [NC-1:0] cell_pulldown_en,
    output logic c0_pullup_en,
    output logic adc_pair_swap,
    output logic irq
);
    // cells come in odd/even pairs sharing two ADCs
    localparam int NP = NC / 2;
    // counter just wide enough for the filter count
    localparam int FW = $clog2(FILT_CYC + 1);

    logic [1:0] rst_sync_r;
    logic rst_n;
    logic [1:0] ctrl_r;
    logic [NC-1:0] cell_en_r;
    scod_sum_t sum_ov_th_r;
    scod_sum_t sum_uv_th_r;
    scod_res_t open_th_r;
    scod_res_t huge_th_r;
    scod_res_t mism_lim_r;
    scod_sum_t sum_r;
    scod_sum_t sum_nxt;
    logic [5:0] stk_flags_r;
    logic [5:0] stk_nxt;
    logic [5:0] stk_set;
    logic [5:0] stk_mask_r;
    logic [NC:0] open_flags_r;
    logic [NC:0] open_nxt;
    logic [NC:0] open_set;
    logic [NC:0] open_mask_r;
    logic [2:0] cmp_meta_r;
    logic [2:0] cmp_sync_r;
    logic [FW-1:0] wcnt_r [2];
    scod_tstep_t ts_r;
    logic mode_r;
    logic term_hit;
    logic rd_stk;
    logic rd_open;

    // reset released through two flops, asserted at once
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // pins from the analog side: {c0, uv, ov}; meta stage read only here
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_meta_r <= 3'h0;
            cmp_sync_r <= 3'h0;
        end else begin
            cmp_meta_r <= {c0_open_cmp, warn_uv_cmp, warn_ov_cmp};
            cmp_sync_r <= cmp_meta_r;
        end
    end

    // software writes; writes to the flag registers are dropped since
    // only hardware sets them and only a read clears them
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= `SCOD_RST_CTRL;
            cell_en_r <= NC'(`SCOD_RST_CELL_EN);
            sum_ov_th_r <= `SCOD_RST_SUM_OV_TH;
            sum_uv_th_r <= `SCOD_RST_SUM_UV_TH;
            open_th_r <= `SCOD_RST_OPEN_TH;
            huge_th_r <= `SCOD_RST_HUGE_TH;
            mism_lim_r <= `SCOD_RST_MISM_LIM;
            stk_mask_r <= 6'h00;
            open_mask_r <= '0;
        end else if (reg_wr) begin
            case (reg_addr)
                `SCOD_A_CTRL: ctrl_r <= reg_wdata[1:0];
                `SCOD_A_CELL_EN: cell_en_r <= reg_wdata[NC-1:0];
                `SCOD_A_SUM_OV_TH: sum_ov_th_r <= reg_wdata[19:0];
                `SCOD_A_SUM_UV_TH: sum_uv_th_r <= reg_wdata[19:0];
                `SCOD_A_OPEN_TH: open_th_r <= reg_wdata[15:0];
                `SCOD_A_HUGE_TH: huge_th_r <= reg_wdata[15:0];
                `SCOD_A_MISM_LIM: mism_lim_r <= reg_wdata[15:0];
                `SCOD_A_STK_MASK: stk_mask_r <= reg_wdata[5:0];
                `SCOD_A_OPEN_MASK: open_mask_r <= reg_wdata[NC:0];
                default: ;
            endcase
        end
    end

    // swap goes straight to the input mux; off after reset
    assign adc_pair_swap = ctrl_r[`SCOD_CTRL_SWAP];

    // stack sum; 14 x 16-bit results cannot overflow 20 bits
    always_comb begin
        sum_nxt = '0;
        for (int i = 0; i < NC; i++) begin
            sum_nxt = sum_nxt + scod_sum_t'(cell_res[i*16 +: 16]);
        end
    end

    // last stack sum kept for software
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sum_r <= '0;
        end else if (cell_step_done) begin
            sum_r <= sum_nxt;
        end
    end

    // warning comparator persistence counters, cleared on any drop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wcnt_r[0] <= '0;
            wcnt_r[1] <= '0;
        end else begin
            for (int k = 0; k < 2; k++) begin
                if (!cmp_sync_r[k]) begin
                    wcnt_r[k] <= '0;
                end else if (wcnt_r[k] != FW'(FILT_CYC)) begin
                    wcnt_r[k] <= wcnt_r[k] + FW'(1);
                end
            end
        end
    end

    // terminal step sequencing; mode frozen at step start
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ts_r <= SCOD_TS_IDLE;
            mode_r <= 1'b0;
        end else begin
            unique case (ts_r)
                SCOD_TS_IDLE: begin
                    if (term_step_start) begin
                        ts_r <= SCOD_TS_RUN;
                        mode_r <= ctrl_r[`SCOD_CTRL_XCHK];
                    end
                end
                SCOD_TS_RUN: begin
                    if (term_step_done) begin
                        ts_r <= SCOD_TS_IDLE;
                    end
                end
                // a corrupted one-hot code falls back to idle
                default: begin
                    ts_r <= SCOD_TS_IDLE;
                end
            endcase
        end
    end
    assign term_hit = (ts_r == SCOD_TS_RUN) && term_step_done;

    // diagnostic currents: cell pull-downs and the c0 pull-up, never in cross-check mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cell_pulldown_en <= '0;
            c0_pullup_en <= 1'b0;
        end else if (ts_r == SCOD_TS_IDLE && term_step_start &&
                     !ctrl_r[`SCOD_CTRL_XCHK]) begin
            cell_pulldown_en <= cell_en_r;
            c0_pullup_en <= cell_en_r[0];
        end else if (term_hit) begin
            cell_pulldown_en <= '0;
            c0_pullup_en <= 1'b0;
        end
    end

    // stack events from the three mechanisms the warning bits
    // re-set every cycle the condition holds, so a read cannot lose it
    always_comb begin
        stk_set = 6'h00;
        stk_set[`SCOD_F_SUM_OV] = cell_step_done && sum_nxt > sum_ov_th_r;
        stk_set[`SCOD_F_SUM_UV] = cell_step_done && sum_nxt < sum_uv_th_r;
        stk_set[`SCOD_F_CRIT_OV] = supply_step_done &&
            supply_res > `SCOD_CRIT_OV_TH;
        stk_set[`SCOD_F_CRIT_UV] = supply_step_done &&
            supply_res < `SCOD_CRIT_UV_TH;
        stk_set[`SCOD_F_WRN_OV] = wcnt_r[0] == FW'(FILT_CYC);
        stk_set[`SCOD_F_WRN_UV] = wcnt_r[1] == FW'(FILT_CYC);
    end

    // open-wire events; bit 0 is the bottom pin, bit i+1 is cell i+1
    always_comb begin
        open_set = '0;
        if (term_hit && !mode_r) begin
            open_set[0] = cmp_sync_r[2] && cell_en_r[0];
            for (int i = 0; i < NC; i++) begin
                if (cell_en_r[i] && term_drop[i*16 +: 16] > open_th_r) begin
                    open_set[i+1] = 1'b1;
                end
            end
            // even cell with a badly degraded filter also hits the lower
            // odd one; odd indices only, so i-1 never leaves the vector
            for (int i = 1; i < NC; i += 2) begin
                if (cell_en_r[i] && cell_en_r[i-1] &&
                    term_drop[i*16 +: 16] > huge_th_r) begin
                    open_set[i] = 1'b1;
                end
            end
        end else if (term_hit) begin
            for (int p = 0; p < NP; p++) begin
                if (pair_diff(pair_odd_res_lo[p*16 +: 16],
                              pair_even_res_lo[p*16 +: 16]) > mism_lim_r) begin
                    open_set[2*p+1] = cell_en_r[2*p];
                    open_set[2*p+2] = cell_en_r[2*p+1];
                end
            end
        end
    end

    // absolute difference of two results; the larger is always taken
    // first, so neither order can wrap
    function automatic scod_res_t pair_diff(scod_res_t a, scod_res_t b);
        pair_diff = (a > b) ? a - b : b - a;
    endfunction : pair_diff

    // read-clear of flags; a set in the same cycle wins
    // so an event never slips between read and clear
    assign rd_stk = reg_rd && reg_addr == `SCOD_A_STK_FLAGS;
    assign rd_open = reg_rd && reg_addr == `SCOD_A_OPEN_FLAGS;
    assign stk_nxt = (rd_stk ? 6'h00 : stk_flags_r) | stk_set;
    assign open_nxt = (rd_open ? '0 : open_flags_r) | open_set;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stk_flags_r <= 6'h00;
            open_flags_r <= '0;
        end else begin
            stk_flags_r <= stk_nxt;
            open_flags_r <= open_nxt;
        end
    end

    // fault line follows every flag, masked or not
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_line <= 1'b0;
        end else begin
            fault_line <= |stk_nxt || |open_nxt;
        end
    end

    // irq sees only flags whose mask bit is clear; masking never hides
    // a fault from the fault line, only from the interrupt
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(stk_nxt & ~stk_mask_r) || |(open_nxt & ~open_mask_r);
        end
    end

    // routine actions: warnings never touch the routine
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_override <= 1'b0;
            balance_stop_all <= 1'b0;
        end else begin
            cfg_override <= |stk_set[3:0] || |open_set;
            balance_stop_all <= stk_set[`SCOD_F_SUM_UV] ||
                stk_set[`SCOD_F_CRIT_UV];
        end
    end

    // read data, valid the cycle after the strobe only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (!reg_rd) begin
            reg_rdata <= 32'h00000000;
        end else begin
            case (reg_addr)
                `SCOD_A_CTRL: reg_rdata <= {30'h0, ctrl_r};
                `SCOD_A_CELL_EN: reg_rdata <= 32'(cell_en_r);
                `SCOD_A_SUM_OV_TH: reg_rdata <= {12'h000, sum_ov_th_r};
                `SCOD_A_SUM_UV_TH: reg_rdata <= {12'h000, sum_uv_th_r};
                `SCOD_A_OPEN_TH: reg_rdata <= {16'h0000, open_th_r};
                `SCOD_A_HUGE_TH: reg_rdata <= {16'h0000, huge_th_r};
                `SCOD_A_MISM_LIM: reg_rdata <= {16'h0000, mism_lim_r};
                `SCOD_A_STK_FLAGS: reg_rdata <= {26'h0, stk_flags_r};
                `SCOD_A_OPEN_FLAGS: reg_rdata <= 32'(open_flags_r);
                `SCOD_A_STK_MASK: reg_rdata <= {26'h0, stk_mask_r};
                `SCOD_A_OPEN_MASK: reg_rdata <= 32'(open_mask_r);
                `SCOD_A_SUM: reg_rdata <= {12'h000, sum_r};
                default: reg_rdata <= 32'h00000000;
            endcase
        end
    end
endmodule : scod_diag

// ==== scod_map.svh ====
/*
 * Register offsets, field positions, reset values and timing counts
 * of the stack and cell open-wire diagnostic block.
 * Assumes a 25 MHz system clock and byte addresses on an 8-bit bus.
 */
`ifndef SCOD_MAP_SVH
`define SCOD_MAP_SVH

// register byte addresses
`define SCOD_A_CTRL 8'h00
`define SCOD_A_CELL_EN 8'h04
`define SCOD_A_SUM_OV_TH 8'h08
`define SCOD_A_SUM_UV_TH 8'h0c
`define SCOD_A_OPEN_TH 8'h10
`define SCOD_A_HUGE_TH 8'h14
`define SCOD_A_MISM_LIM 8'h18
`define SCOD_A_STK_FLAGS 8'h1c
`define SCOD_A_OPEN_FLAGS 8'h20
`define SCOD_A_STK_MASK 8'h24
`define SCOD_A_OPEN_MASK 8'h28
`define SCOD_A_SUM 8'h2c

// control fields
`define SCOD_CTRL_XCHK 0
`define SCOD_CTRL_SWAP 1

// stack flag positions
`define SCOD_F_SUM_OV 0
`define SCOD_F_SUM_UV 1
`define SCOD_F_CRIT_OV 2
`define SCOD_F_CRIT_UV 3
`define SCOD_F_WRN_OV 4
`define SCOD_F_WRN_UV 5

// reset values
`define SCOD_RST_CTRL 2'h0
`define SCOD_RST_CELL_EN 14'h3fff
`define SCOD_RST_SUM_OV_TH 20'hfffff
`define SCOD_RST_SUM_UV_TH 20'h00000
`define SCOD_RST_OPEN_TH 16'h0100
`define SCOD_RST_HUGE_TH 16'h0800
`define SCOD_RST_MISM_LIM 16'h0040

// fixed critical thresholds on the supply conversion result
`define SCOD_CRIT_OV_TH 16'hf000
`define SCOD_CRIT_UV_TH 16'h1000

// supply filter time, rounded up to whole clock cycles
`define SCOD_CLK_MHZ 25
`define SCOD_FILT_NS 100000
`define SCOD_FILT_CYC ((`SCOD_FILT_NS * `SCOD_CLK_MHZ + 999) / 1000)

`endif

// ==== scod_pkg.sv ====
/*
 * Types shared by the stack and cell open-wire diagnostic block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package scod_pkg;
    typedef logic [19:0] scod_sum_t;
    typedef logic [15:0] scod_res_t;
    typedef enum logic [1:0] {
        SCOD_TS_IDLE = 2'b01,
        SCOD_TS_RUN = 2'b10
    } scod_tstep_t;
endpackage : scod_pkg

// ==== scod_host.sv ====
/* host-side model: register bus master tasks.
   assumes clk from the bench; tasks entered just after a rising edge */
`timescale 1ns/1ps
module scod_host (
    input wire logic clk,
    output logic [7:0] reg_addr,
    output logic [31:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [31:0] reg_rdata
);
    // bus idle from time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // one-cycle write; the #1 returns just after the edge so the written register is seen
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
endmodule : scod_host

// ==== scod_diag_chk.sv ====
/* checker: port-level assertions on scod_diag.
   assumes it is bound to scod_diag, single clock domain */
`timescale 1ns/1ps
`include "scod_map.svh"
module scod_diag_chk
    import scod_pkg::*;
#(
    parameter int NC = 14,
    parameter int FILT_CYC = `SCOD_FILT_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic cell_step_done,
    input wire logic supply_step_done,
    input wire logic [15:0] supply_res,
    input wire logic term_step_done,
    input wire logic warn_ov_cmp,
    input wire logic warn_uv_cmp,
    input wire logic fault_line,
    input wire logic cfg_override,
    input wire logic balance_stop_all,
    input wire logic [NC-1:0] cell_pulldown_en
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    int ov_n;
    int uv_n;
    // consecutive high cycles per comparator, saturating
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ov_n <= 0;
            uv_n <= 0;
        end else begin
            ov_n <= warn_ov_cmp ? ov_n + int'(ov_n < 999) : 0;
            uv_n <= warn_uv_cmp ? uv_n + int'(uv_n < 999) : 0;
        end
    end
    sequence s_crit_ov;
        supply_step_done && supply_res > `SCOD_CRIT_OV_TH;
    endsequence
    sequence s_crit_uv;
        supply_step_done && supply_res < `SCOD_CRIT_UV_TH;
    endsequence
    property p_crit_ov;
        s_crit_ov |=> fault_line && cfg_override;
    endproperty
    property p_crit_uv;
        s_crit_uv |=> fault_line && cfg_override && balance_stop_all;
    endproperty
    property p_ovr_fault;
        cfg_override |-> fault_line;
    endproperty
    property p_stop;
        balance_stop_all |-> cfg_override;
    endproperty
    // warnings never reach the routine, so override needs a step
    property p_ovr_cause;
        cfg_override |-> $past(cell_step_done) || $past(supply_step_done)
            || $past(term_step_done);
    endproperty
    property p_pd_off;
        term_step_done && (|cell_pulldown_en) |=> cell_pulldown_en == '0;
    endproperty
    property p_hold;
        fault_line && !reg_rd |=> fault_line;
    endproperty
    // margin covers the two sync stages and the flag flop
    property p_warn_ov;
        ov_n >= FILT_CYC + 6 |-> fault_line;
    endproperty
    property p_warn_uv;
        uv_n >= FILT_CYC + 6 |-> fault_line;
    endproperty
    property p_rd_idle;
        !reg_rd |=> reg_rdata == '0;
    endproperty
    a_crit_ov: assert property (p_crit_ov)
        else $error("critical over-voltage not reported");
    a_crit_uv: assert property (p_crit_uv)
        else $error("critical under-voltage not reported");
    a_ovr_fault: assert property (p_ovr_fault)
        else $error("override without fault line");
    a_stop: assert property (p_stop)
        else $error("balance stop without override");
    a_ovr_cause: assert property (p_ovr_cause)
        else $error("override without a routine step");
    a_pd_off: assert property (p_pd_off)
        else $error("pull-down left on after step");
    a_hold: assert property (p_hold)
        else $error("fault line dropped without a read");
    a_warn_ov: assert property (p_warn_ov)
        else $error("held over-voltage warning not flagged");
    a_warn_uv: assert property (p_warn_uv)
        else $error("held under-voltage warning not flagged");
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read cycle");
endmodule : scod_diag_chk

bind scod_diag scod_diag_chk #(.NC(NC), .FILT_CYC(FILT_CYC)) chk (
    .clk(clk), .nrst(nrst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cell_step_done(cell_step_done), .supply_step_done(supply_step_done),
    .supply_res(supply_res), .term_step_done(term_step_done),
    .warn_ov_cmp(warn_ov_cmp), .warn_uv_cmp(warn_uv_cmp),
    .fault_line(fault_line), .cfg_override(cfg_override),
    .balance_stop_all(balance_stop_all),
    .cell_pulldown_en(cell_pulldown_en));

// ==== scod_tb.sv ====
/* testbench for scod_diag with the host model.
   assumes short filter count FC for a quick run */
`timescale 1ns/1ps
`include "scod_map.svh"
module tb;
    import scod_pkg::*;
    localparam int NC = 14;
    localparam int FC = 8;
    localparam int SCAN_GAP = 8; // normal scan spacing in cycles
    logic clk, nrst, reg_wr, reg_rd, c0_open_cmp, warn_ov_cmp, warn_uv_cmp;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rv;
    logic cell_step_done, supply_step_done, term_step_start, term_step_done;
    logic [NC*16-1:0] cell_res, term_drop;
    logic [NC*8-1:0] pair_odd_res_lo, pair_even_res_lo;
    scod_res_t supply_res;
    logic fault_line, cfg_override, balance_stop_all, c0_pullup_en;
    logic adc_pair_swap, irq;
    logic [NC-1:0] cell_pulldown_en;
    int fail_count, n_checks;
    scod_diag #(.NC(NC), .FILT_CYC(FC)) uut (.clk(clk), .nrst(nrst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cell_step_done(cell_step_done), .cell_res(cell_res),
        .supply_step_done(supply_step_done), .supply_res(supply_res),
        .term_step_start(term_step_start), .term_step_done(term_step_done),
        .term_drop(term_drop), .pair_odd_res_lo(pair_odd_res_lo),
        .pair_even_res_lo(pair_even_res_lo), .c0_open_cmp(c0_open_cmp),
        .warn_ov_cmp(warn_ov_cmp), .warn_uv_cmp(warn_uv_cmp),
        .fault_line(fault_line), .cfg_override(cfg_override),
        .balance_stop_all(balance_stop_all),
        .cell_pulldown_en(cell_pulldown_en), .c0_pullup_en(c0_pullup_en),
        .adc_pair_swap(adc_pair_swap), .irq(irq));
    scod_host host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        host.rd(a, rv);
        chk($sformatf("reg %h", a), e, rv);
    endtask : rchk
    // one-cycle strobe; registered answers are seen just after the edge
    task automatic pls(input int k);
        case (k)
            0: cell_step_done <= 1'b1;
            1: supply_step_done <= 1'b1;
            2: term_step_start <= 1'b1;
            default: term_step_done <= 1'b1;
        endcase
        @(posedge clk);
        cell_step_done <= 1'b0;
        supply_step_done <= 1'b0;
        term_step_start <= 1'b0;
        term_step_done <= 1'b0;
        #1;
    endtask : pls
    task automatic t_sum;
        host.wr(`SCOD_A_SUM_OV_TH, 32'he000);
        pls(0);
        chk("ovr at equal", 0, cfg_override);
        host.wr(`SCOD_A_SUM_OV_TH, 32'hdfff);
        pls(0);
        chk("sum ovr", 1, cfg_override);
        rchk(`SCOD_A_STK_FLAGS, 32'h1);
        rchk(`SCOD_A_SUM, 32'he000);
        chk("fault cleared", 0, fault_line);
        host.wr(`SCOD_A_SUM_OV_TH, 32'hfffff);
        host.wr(`SCOD_A_SUM_UV_TH, 32'he001);
        pls(0);
        chk("sum stop", 1, balance_stop_all);
        rchk(`SCOD_A_STK_FLAGS, 32'h2);
        host.wr(`SCOD_A_SUM_UV_TH, 32'h0);
    endtask : t_sum
    task automatic t_crit;
        supply_res <= 16'hf001;
        pls(1);
        chk("crit ovr", 1, cfg_override);
        rchk(`SCOD_A_STK_FLAGS, 32'h4);
        supply_res <= 16'h0fff;
        pls(1);
        chk("crit stop", 1, balance_stop_all);
        rchk(`SCOD_A_STK_FLAGS, 32'h8);
        supply_res <= 16'h8000;
    endtask : t_crit
    task automatic t_warn;
        int ov;
        for (int k = 0; k < 2; k++) begin
            ov = 0;
            {warn_uv_cmp, warn_ov_cmp} <= 2'b01 << k;
            repeat (FC - 2) @(posedge clk);
            {warn_uv_cmp, warn_ov_cmp} <= 2'b00;
            repeat (4) @(posedge clk);
            #1 chk("short warn", 0, fault_line);
            {warn_uv_cmp, warn_ov_cmp} <= 2'b01 << k;
            repeat (FC + 8) begin
                @(posedge clk);
                #1 ov += int'(cfg_override);
            end
            chk("warn fault", 1, fault_line);
            chk("warn ovr", 0, ov);
            {warn_uv_cmp, warn_ov_cmp} <= 2'b00;
            repeat (4) @(posedge clk);
            #1 rchk(`SCOD_A_STK_FLAGS, 32'h10 << k);
        end
    endtask : t_warn
    // odd cell 3, huge drop on even cell 6, cell 8 disabled, cell 10 equal
    task automatic t_open;
        host.wr(`SCOD_A_CELL_EN, 32'h3f7f);
        term_drop[2*16+:16] <= 16'h0101;
        term_drop[5*16+:16] <= 16'h0801;
        term_drop[7*16+:16] <= 16'hffff;
        term_drop[9*16+:16] <= 16'h0100;
        c0_open_cmp <= 1'b1;
        pls(2);
        chk("pd en", 32'h3f7f, cell_pulldown_en);
        chk("c0 pullup", 1, c0_pullup_en);
        repeat (3) @(posedge clk);
        #1 pls(3);
        chk("open ovr", 1, cfg_override);
        rchk(`SCOD_A_OPEN_FLAGS, 32'h69);
        c0_open_cmp <= 1'b0;
        term_drop <= '0;
        host.wr(`SCOD_A_CELL_EN, 32'h3fff);
    endtask : t_open
    // pair 1 beyond the limit, pair 2 exactly at it, pair 3 just beyond
    // it with the even side higher
    task automatic t_xchk;
        host.wr(`SCOD_A_CTRL, 32'h1);
        pair_odd_res_lo[16+:16] <= 16'h0100;
        pair_odd_res_lo[32+:16] <= 16'h0040;
        pair_even_res_lo[48+:16] <= 16'h0041;
        pls(2);
        chk("no pd", 0, cell_pulldown_en);
        pls(3);
        chk("xchk ovr", 1, cfg_override);
        rchk(`SCOD_A_OPEN_FLAGS, 32'h198);
        pair_odd_res_lo <= '0;
        pair_even_res_lo <= '0;
        host.wr(`SCOD_A_CTRL, 32'h0);
    endtask : t_xchk
    // host limp-home order: swap off scan, then swap on scan, with the write,
    // the read-back and half the normal scan gap between them
    task automatic t_swap;
        pls(0);
        chk("swap idle", 0, adc_pair_swap);
        host.wr(`SCOD_A_CTRL, 32'h2);
        chk("swap on", 1, adc_pair_swap);
        rchk(`SCOD_A_CTRL, 32'h2);
        repeat (SCAN_GAP / 2) @(posedge clk);
        #1 pls(0);
        rchk(`SCOD_A_SUM, 32'he000);
        host.wr(`SCOD_A_CTRL, 32'h0);
        chk("swap off", 0, adc_pair_swap);
    endtask : t_swap
    task automatic t_irq;
        host.wr(`SCOD_A_STK_MASK, 32'h3f);
        supply_res <= 16'hf001;
        pls(1);
        repeat (2) @(posedge clk);
        #1 chk("irq masked", 0, irq);
        chk("fault masked", 1, fault_line);
        host.wr(`SCOD_A_STK_MASK, 32'h0);
        @(posedge clk);
        #1 chk("irq raised", 1, irq);
        rchk(`SCOD_A_STK_FLAGS, 32'h4);
        @(posedge clk);
        #1 chk("irq cleared", 0, irq);
        supply_res <= 16'h8000;
    endtask : t_irq
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict
    // all scenarios need well under 200 cycles; this is ample
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        print_verdict();
    end
    initial begin
        {nrst, cell_step_done, supply_step_done} = 3'b000;
        {term_step_start, term_step_done, c0_open_cmp} = 3'b000;
        {warn_ov_cmp, warn_uv_cmp} = 2'b00;
        cell_res = {NC{16'h1000}};
        term_drop = '0;
        pair_odd_res_lo = '0;
        pair_even_res_lo = '0;
        supply_res = 16'h8000;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        #1 chk("swap rst", 0, adc_pair_swap);
        rchk(`SCOD_A_CTRL, 32'h0);
        rchk(`SCOD_A_CELL_EN, 32'h3fff);
        rchk(8'hfc, 32'h0);
        t_sum();
        t_crit();
        t_warn();
        t_open();
        t_xchk();
        t_swap();
        t_irq();
        print_verdict();
    end
endmodule : tb
